/* File: hw/acp_top.v */
// ADC pair input control registers with AXI4-Lite slave
// Assumes one 20 MHz clock; mic pins asynchronous, synchronised here
// Operation
// - Pair registers at 0x1D and 0x1E, eight bits, R/W, reset zero, bit 7 reserved
// - Pair 0/1 bits 6:5 pick high-pass: off, 1 Hz, 4 Hz, 8 Hz
// - Pair 2/3 bits 6:5 use the same high-pass encoding
// - Bit 4 inverts digital microphone polarity for its pair
// - Bit 3 clear: left on rising mic clock edge, right on falling
// - Bit 3 set swaps left and right microphone channels
// - Bit 2 feeds decimators from microphones, else from analog converters
// - Bit 0 enables lower channel, bit 1 the higher channel
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "acp_defs.vh"
module acp_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [9:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [9:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Digital microphone pins
  input wire [1:0] mic_clk,
  input wire [1:0] mic_data,
  // Pair settings out
  output reg [3:0] hp_sel_a_q,
  output reg [3:0] hp_sel_b_q,
  output reg [1:0] decim_src_dmic_q,
  output reg [3:0] ch_active_q,
  // Microphone channel bits, four channels
  output wire [3:0] mic_bit,
  output wire [3:0] mic_vld
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] pair01_q;
  reg [7:0] pair23_q;
  reg [7:0] decpwr_q;
  reg aw_held_q;
  reg w_held_q;
  reg [9:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [7:0] pair01_d;
  reg [7:0] pair23_d;
  reg [7:0] decpwr_d;

  function [7:0] word_idx;
    input [9:0] addr;
    begin
      word_idx = addr[9:2];
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx == `ACP_IDX_PAIR01) || (idx == `ACP_IDX_PAIR23) ||
               (idx == `ACP_IDX_DECPWR) || (idx == `ACP_IDX_STATUS);
    end
  endfunction

  function hit;
    input [7:0] idx;
    input [7:0] sel;
    begin
      hit = (idx == sel);
    end
  endfunction

  function [7:0] ctrl_byte;
    input [31:0] d;
    begin
      ctrl_byte = d[7:0] & `ACP_PAIR_MASK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  wire [9:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_fire;
  wire [7:0] wr_idx;
  wire wr_byte0;
  wire wr_pair01;
  wire wr_pair23;
  wire wr_decpwr;
  wire [1:0] wr_resp;
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  assign wr_fire = ~s_axi_bvalid & (aw_held_q | s_axi_awvalid) & (w_held_q | s_axi_wvalid);
  assign wr_idx = word_idx(wr_addr);
  assign wr_byte0 = wr_fire & wr_strb[0];
  assign wr_pair01 = wr_byte0 & hit(wr_idx, `ACP_IDX_PAIR01);
  assign wr_pair23 = wr_byte0 & hit(wr_idx, `ACP_IDX_PAIR23);
  assign wr_decpwr = wr_byte0 & hit(wr_idx, `ACP_IDX_DECPWR);
  assign wr_resp = mapped(wr_idx) ? `ACP_RESP_OKAY : `ACP_RESP_SLVERR;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 10'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACP_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, bit 7 reserved and held at zero
  always @* begin
    pair01_d = pair01_q;
    pair23_d = pair23_q;
    decpwr_d = decpwr_q;
    if (wr_pair01) begin
      pair01_d = ctrl_byte(wr_data);
    end
    if (wr_pair23) begin
      pair23_d = ctrl_byte(wr_data);
    end
    if (wr_decpwr) begin
      decpwr_d = wr_data[7:0] & `ACP_DECPWR_MASK;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pair01_q <= `ACP_RST_CTRL;
      pair23_q <= `ACP_RST_CTRL;
      decpwr_q <= `ACP_RST_DECPWR;
    end else begin
      pair01_q <= pair01_d;
      pair23_q <= pair23_d;
      decpwr_q <= decpwr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair decode
  wire [3:0] hp_a;
  wire [3:0] hp_b;
  wire [1:0] pol;
  wire [1:0] swap;
  wire [1:0] src;
  wire [3:0] act;

  acp_pair_ctrl u_pair_a (
    .ctrl(pair01_q),
    .sinc_en(decpwr_q[1:0]),
    .hp_onehot(hp_a),
    .pol_invert(pol[0]),
    .lr_swap(swap[0]),
    .src_dmic(src[0]),
    .ch_active(act[1:0])
  );

  acp_pair_ctrl u_pair_b (
    .ctrl(pair23_q),
    .sinc_en(decpwr_q[3:2]),
    .hp_onehot(hp_b),
    .pol_invert(pol[1]),
    .lr_swap(swap[1]),
    .src_dmic(src[1]),
    .ch_active(act[3:2])
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      hp_sel_a_q <= `ACP_RST_HP;
      hp_sel_b_q <= `ACP_RST_HP;
      decim_src_dmic_q <= 2'h0;
      ch_active_q <= 4'h0;
    end else begin
      hp_sel_a_q <= hp_a;
      hp_sel_b_q <= hp_b;
      decim_src_dmic_q <= src;
      ch_active_q <= act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microphone synchronisers and lanes
  reg [1:0] mclk_m_q;
  reg [1:0] mclk_s_q;
  reg [1:0] mdat_m_q;
  reg [1:0] mdat_s_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mclk_m_q <= 2'h0;
      mclk_s_q <= 2'h0;
      mdat_m_q <= 2'h0;
      mdat_s_q <= 2'h0;
    end else begin
      mclk_m_q <= mic_clk;
      mclk_s_q <= mclk_m_q;
      mdat_m_q <= mic_data;
      mdat_s_q <= mdat_m_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
      acp_dmic_lane u_lane (
        .aclk(aclk),
        .aresetn(aresetn),
        .lr_swap(swap[gi]),
        .pol_invert(pol[gi]),
        .ch_active(act[2*gi+1:2*gi]),
        .mic_clk_s(mclk_s_q[gi]),
        .mic_data_s(mdat_s_q[gi]),
        .left_bit_q(mic_bit[2*gi]),
        .right_bit_q(mic_bit[2*gi+1]),
        .left_vld_q(mic_vld[2*gi]),
        .right_vld_q(mic_vld[2*gi+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  wire [7:0] rd_idx;
  reg [7:0] rd_byte;
  wire [7:0] status_byte;
  wire [1:0] rd_resp;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = word_idx(s_axi_araddr);
  assign status_byte = {2'h0, src, act};
  assign rd_resp = mapped(rd_idx) ? `ACP_RESP_OKAY : `ACP_RESP_SLVERR;

  always @* begin
    case (rd_idx)
      `ACP_IDX_PAIR01: rd_byte = pair01_q;
      `ACP_IDX_PAIR23: rd_byte = pair23_q;
      `ACP_IDX_DECPWR: rd_byte = decpwr_q;
      `ACP_IDX_STATUS: rd_byte = status_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_resp;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // acp_top
`default_nettype wire

/* File: hw/acp_defs.vh */
// Constants for the ADC pair input control block
// Assumes inclusion by bare name from files under hw/
`ifndef ACP_DEFS_VH
`define ACP_DEFS_VH
// Printed register indices (byte address is four times the index)
`define ACP_IDX_PAIR01 8'h1D
`define ACP_IDX_PAIR23 8'h1E
`define ACP_IDX_DECPWR 8'h1A
`define ACP_IDX_STATUS 8'h1B
// Reset values
`define ACP_RST_CTRL 8'h00
`define ACP_RST_DECPWR 8'h00
`define ACP_RST_HP 4'h1
// Writable bits
`define ACP_PAIR_MASK 8'h7F
`define ACP_DECPWR_MASK 8'h0F
// Field positions
`define ACP_HP_HI 6
`define ACP_HP_LO 5
`define ACP_POL_BIT 4
`define ACP_SWAP_BIT 3
`define ACP_SRC_BIT 2
`define ACP_EN_HI_BIT 1
`define ACP_EN_LO_BIT 0
// High-pass codes
`define ACP_HP_OFF 2'h0
`define ACP_HP_1HZ 2'h1
`define ACP_HP_4HZ 2'h2
`define ACP_HP_8HZ 2'h3
// AXI responses
`define ACP_RESP_OKAY 2'h0
`define ACP_RESP_SLVERR 2'h2
`endif

/* File: hw/acp_pair_ctrl.v */
// One channel pair: decodes a control byte into pair settings
// Assumes a register byte from the bus slave and sinc enables from outside
`timescale 1ns/100ps
`default_nettype none
`include "acp_defs.vh"
module acp_pair_ctrl (
  // Control byte and decimator enables
  input wire [7:0] ctrl,
  input wire [1:0] sinc_en,
  // Pair settings
  output wire [3:0] hp_onehot,
  output wire pol_invert,
  output wire lr_swap,
  output wire src_dmic,
  output wire [1:0] ch_active
);
  wire [1:0] hp_sel;
  assign hp_sel = ctrl[`ACP_HP_HI:`ACP_HP_LO];
  // Bypass, 1 Hz, 4 Hz, 8 Hz corners
  assign hp_onehot[0] = (hp_sel == `ACP_HP_OFF);
  assign hp_onehot[1] = (hp_sel == `ACP_HP_1HZ);
  assign hp_onehot[2] = (hp_sel == `ACP_HP_4HZ);
  assign hp_onehot[3] = (hp_sel == `ACP_HP_8HZ);
  assign pol_invert = ctrl[`ACP_POL_BIT];
  assign lr_swap = ctrl[`ACP_SWAP_BIT];
  assign src_dmic = ctrl[`ACP_SRC_BIT];
  // Channel fully on only with both enables
  assign ch_active[0] = ctrl[`ACP_EN_LO_BIT] & sinc_en[0];
  assign ch_active[1] = ctrl[`ACP_EN_HI_BIT] & sinc_en[1];
endmodule // acp_pair_ctrl
`default_nettype wire

/* File: hw/acp_dmic_lane.v */
// One digital microphone lane: edge select, swap, polarity
// Assumes synchronised mic clock and data levels on aclk
`timescale 1ns/100ps
`default_nettype none
module acp_dmic_lane (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Pair settings
  input wire lr_swap,
  input wire pol_invert,
  input wire [1:0] ch_active,
  // Synchronised microphone inputs
  input wire mic_clk_s,
  input wire mic_data_s,
  // Decoded bits
  output reg left_bit_q,
  output reg right_bit_q,
  output reg left_vld_q,
  output reg right_vld_q
);
  reg clk_prev_q;
  wire rise;
  wire fall;
  wire bit_val;
  wire take_left;
  wire take_right;
  assign rise = mic_clk_s & ~clk_prev_q;
  assign fall = ~mic_clk_s & clk_prev_q;
  assign bit_val = mic_data_s ^ pol_invert;
  // Left on rising edge unless swapped
  assign take_left = lr_swap ? fall : rise;
  assign take_right = lr_swap ? rise : fall;
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q <= 1'b0;
      left_bit_q <= 1'b0;
      right_bit_q <= 1'b0;
      left_vld_q <= 1'b0;
      right_vld_q <= 1'b0;
    end else begin
      clk_prev_q <= mic_clk_s;
      left_vld_q <= take_left & ch_active[0];
      right_vld_q <= take_right & ch_active[1];
      if (take_left) begin
        left_bit_q <= bit_val;
      end
      if (take_right) begin
        right_bit_q <= bit_val;
      end
    end
  end
endmodule // acp_dmic_lane
`default_nettype wire

/* File: dv/acp_top_props.sv */
// Checker for acp_top bus handshakes and pair settings
// Assumes binding to acp_top, one clock, sync active-low reset
`timescale 1ns/100ps
`default_nettype none
module acp_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pair settings
  input wire logic [3:0] hp_sel_a_q,
  input wire logic [3:0] hp_sel_b_q,
  input wire logic [3:0] ch_active_q,
  input wire logic [3:0] mic_vld
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rst;
    $rose(aresetn) |-> hp_sel_a_q == 4'h1 && hp_sel_b_q == 4'h1 && ch_active_q == 4'h0
      && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_wr; s_wr_take |=> s_axi_bvalid; endproperty
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rd; s_ar_take |=> s_axi_rvalid && s_axi_rdata[31:7] == 25'h0; endproperty
  property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_hpa; $onehot(hp_sel_a_q); endproperty
  property p_hpb; $onehot(hp_sel_b_q); endproperty
  property p_act; (ch_active_q == 4'h0) [*6] |-> mic_vld == 4'h0; endproperty
  ////////////////////////////////////////////////////////////
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_wr: assert property (p_wr) else $error("no write response");
  a_bblk: assert property (p_bblk) else $error("ready during response");
  a_rd: assert property (p_rd) else $error("read reply wrong");
  a_rblk: assert property (p_rblk) else $error("arready during rvalid");
  a_rdone: assert property (p_rdone) else $error("rvalid stuck");
  a_hpa: assert property (p_hpa) else $error("pair a filter not onehot");
  a_hpb: assert property (p_hpb) else $error("pair b filter not onehot");
  a_act: assert property (p_act) else $error("valid on idle channel");
endmodule // acp_top_props
bind acp_top acp_top_props chk_i (.*);
`default_nettype wire

/* File: dv/tb_acp_top.sv */
// Testbench for acp_top: registers, settings, mic lanes
// Assumes acp_defs.vh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "acp_defs.vh"
module tb_acp_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, rnd = 32'hDA15, v, d;
  logic [3:0] s_axi_wstrb = 4'hF, ex;
  logic [1:0] mic_clk = 0, mic_data = 0, r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, decim_src_dmic_q;
  wire [31:0] s_axi_rdata;
  wire [3:0] hp_sel_a_q, hp_sel_b_q, ch_active_q, mic_bit, mic_vld;
  integer err_count = 0, n_compared = 0, p, c, s;
  logic [6:0] m [0:1];
  integer nvld = 0;
  acp_top dut (.*);
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    nvld <= nvld + mic_vld[0] + mic_vld[1] + mic_vld[2] + mic_vld[3];
  end
  ////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] q);
    lfsr = {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
  endfunction
  function [9:0] ap(input integer q);
    ap = q ? {`ACP_IDX_PAIR23, 2'h0} : {`ACP_IDX_PAIR01, 2'h0};
  endfunction
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input [9:0] a, input [31:0] dat, output [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [9:0] a, output [31:0] dat, output [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task end_sim;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (p = 0; p < 2; p++) begin
      rd(ap(p), d, r);
      chk("reset", d, `ACP_RST_CTRL);
    end
    // Every filter code on both pairs, random other bits
    for (p = 0; p < 2; p++) begin
      for (c = 0; c < 4; c++) begin
        rnd = lfsr(rnd);
        v = {rnd[31:7], c[1:0], rnd[4:0]};
        m[p] = v[6:0];
        wr(ap(p), v, r);
        chk("bresp", r, `ACP_RESP_OKAY);
        rd(ap(p), d, r);
        chk("rdata", d, {25'h0, m[p]});
        chk("hp", p ? hp_sel_b_q : hp_sel_a_q, 4'h1 << c);
        chk("src", decim_src_dmic_q[p], v[2]);
      end
    end
    // Unmapped place
    wr(10'h010, 32'hFF, r);
    chk("ubresp", r, `ACP_RESP_SLVERR);
    rd(10'h010, d, r);
    chk("urresp", r, `ACP_RESP_SLVERR);
    chk("udata", d, 0);
    // Byte 0 strobe clear leaves the register alone
    s_axi_wstrb <= 4'hE;
    wr(ap(0), 32'h55, r);
    chk("sbresp", r, `ACP_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ap(0), d, r);
    chk("sdata", d, {25'h0, m[0]});
    // Channel active needs enable and sinc enable
    for (c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      wr(ap(0), rnd[5:4], r);
      wr(ap(1), rnd[7:6], r);
      wr({`ACP_IDX_DECPWR, 2'h0}, rnd[3:0], r);
      ex = rnd[3:0] & rnd[7:4];
      repeat (3) @(posedge aclk);
      chk("active", ch_active_q, ex);
      rd({`ACP_IDX_DECPWR, 2'h0}, d, r);
      chk("decpwr", d, rnd[3:0]);
      rd({`ACP_IDX_STATUS, 2'h0}, d, r);
      chk("status", d, ex);
    end
    // Mid-run reset returns both pair registers to zero and pair 0/1 filter select to bypass
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (p = 0; p < 2; p++) begin
      rd(ap(p), d, r);
      chk("reset2", d, `ACP_RST_CTRL);
    end
    chk("hpreset", hp_sel_a_q, 4'h1);
    // Both mic lanes: polarity and swap
    wr({`ACP_IDX_DECPWR, 2'h0}, 32'hF, r);
    for (p = 0; p < 2; p++) begin
      for (s = 0; s < 4; s++) begin
        wr(ap(p), {27'h0, s[0], s[1], 3'h7}, r);
        rnd = lfsr(rnd);
        mic_data[p] <= rnd[0];
        repeat (4) @(posedge aclk);
        mic_clk[p] <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("rise", mic_bit[2 * p + s[1]], rnd[0] ^ s[0]);
        mic_data[p] <= rnd[1];
        repeat (4) @(posedge aclk);
        mic_clk[p] <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("fall", mic_bit[2 * p + !s[1]], rnd[1] ^ s[0]);
      end
    end
    chk("pulses", nvld, 16);
    // Sinc enables off: edges decode but no channel reports
    wr({`ACP_IDX_DECPWR, 2'h0}, 32'h0, r);
    mic_clk[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    mic_clk[0] <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("idle", nvld, 16);
    end_sim;
  end
endmodule // tb_acp_top
`default_nettype wire
